/* File: core/sbac_line.sv */
/*
  Samples the clock and data pins of the two-wire bus into the system
  clock domain and finds clock edges, start and stop conditions.
  Assumes the bus clock is much slower than clk (8 clk per bus bit).
*/
`timescale 1ns/10ps
module sbac_line (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic scl_i,
  input  wire logic sda_i,
  sbac_line_if.line ev
);

  logic scl_m_q;
  logic scl_s_q;
  logic scl_d_q;
  logic sda_m_q;
  logic sda_s_q;
  logic sda_d_q;

  // ----------------------------------------------------------------
  // Two-stage synchronisers, then one delay stage for edges
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_d_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_d_q <= 1'b1;
    end else begin
      scl_m_q <= scl_i;
      scl_s_q <= scl_m_q;
      scl_d_q <= scl_s_q;
      sda_m_q <= sda_i;
      sda_s_q <= sda_m_q;
      sda_d_q <= sda_s_q;
    end
  end

  assign ev.scl_rise  = scl_s_q & ~scl_d_q;
  assign ev.scl_fall  = ~scl_s_q & scl_d_q;
  assign ev.start_det = scl_s_q & scl_d_q & sda_d_q & ~sda_s_q;
  assign ev.stop_det  = scl_s_q & scl_d_q & ~sda_d_q & sda_s_q;
  assign ev.sda_bit   = sda_s_q;

endmodule : sbac_line

/* File: core/sbac_line_if.sv */
/*
  Line events passed from the pin sampler to the byte access core.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/10ps
interface sbac_line_if;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic sda_bit;

  modport line (output scl_rise, output scl_fall, output start_det,
                output stop_det, output sda_bit);
  modport core (input scl_rise, input scl_fall, input start_det,
                input stop_det, input sda_bit);
endinterface : sbac_line_if

/* File: core/sbac_pkg.sv */
/*
  Shared constants and types for the two-wire byte access path and the
  first control register of the clock synthesizer configuration port.
  Assumes nothing of its surroundings; imported by scoped name only.
*/
package sbac_pkg;

  // ----------------------------------------------------------------
  // Bus addressing and command decode
  // ----------------------------------------------------------------
  localparam logic [7:0] SLAVE_ADDR_W   = 8'hD2;
  localparam int         CMD_BYTE_BIT   = 7;
  localparam logic [7:0] BLOCK_CMD      = 8'h00;
  localparam logic [7:0] BLOCK_COUNT    = 8'h01;
  localparam logic [7:0] UNMAPPED_READ  = 8'h00;
  localparam logic [6:0] REG0_INDEX     = 7'h00;

  // ----------------------------------------------------------------
  // Control register 0 field positions
  // ----------------------------------------------------------------
  localparam int STRAP_HIGH_BIT = 7;
  localparam int STRAP_MID_BIT  = 6;
  localparam int STRAP_LOW_BIT  = 5;
  localparam int MGMT_BIT       = 4;
  localparam int RSVD_BIT       = 3;
  localparam int REF_SEL_BIT    = 2;
  localparam int SATA_SEL_BIT   = 1;
  localparam int PWR_DN_CFG_BIT = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic       MGMT_RST       = 1'b0;
  localparam logic       RSVD_RST       = 1'b0;
  localparam logic       SATA_SEL_RST   = 1'b0;
  localparam logic       PWR_DN_CFG_RST = 1'b1;
  localparam logic [1:0] ALLOC_MODE_PROC = 2'h0;
  localparam logic [3:0] EXPRESS_CFG_OFF = 4'h0;

  // ----------------------------------------------------------------
  // Slave protocol states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SBAC_IDLE,
    SBAC_ADDR,
    SBAC_CMD,
    SBAC_WDATA,
    SBAC_ACK,
    SBAC_RDATA,
    SBAC_MACK
  } sbac_state_t;

endpackage : sbac_pkg

/* File: core/sbac_top.sv */
/*
  Two-wire byte access slave and control register 0 of the clock
  synthesizer: straps, management mode, loop source selects and the
  power-down behaviour select.
  Assumes an open-drain bus resolved outside, a bus clock of about
  2.5 MHz against a 20 MHz clk, and asynchronous strap pins.
*/
// Operation
// - Acknowledge address, command and data bytes
// - Command MSB set selects byte access
// - Command low seven bits give offset
// - Byte read ends with master NACK, stop
// - Bits 7..5 read latched strap pins
// - Bit 4 selects management mode, resets 0
// - Management bit sticky until reset or power-down full reset
// - Bit 2 picks processor or express loop
// - Express source overrides second register field
// - Bit 2 reset follows loop allocation mode
// - Bit 1 picks SATA source, resets 0
// - Bit 0 low: power-down causes full reset
// - Bit 0 high: legacy power-down, keep config
// - Answer only slave address D2h
// - Command zero selects sequential block access
`timescale 1ns/10ps
module sbac_top (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_n,
  input  wire logic       freq_strap_high,
  input  wire logic       freq_strap_mid,
  input  wire logic       freq_strap_low,
  input  wire logic [1:0] pll_alloc_mode,
  input  wire logic       power_down_n,
  input  wire logic [3:0] second_reg_cfg,
  output logic [2:0]      freq_strap_latched,
  output logic            management_mode,
  output logic            ref_from_express_loop,
  output logic [3:0]      express_cfg_eff,
  output logic            sata_from_usb_rate_loop,
  output logic            legacy_power_down,
  output logic [7:0]      reg0_value
);

  sbac_line_if            ev ();
  sbac_pkg::sbac_state_t  st_q;
  sbac_pkg::sbac_state_t  nxt_q;
  logic [7:0]             sh_q;
  logic [7:0]             tx_q;
  logic [2:0]             cnt_q;
  logic                   full_q;
  logic [6:0]             off_q;
  logic                   block_q;
  logic                   count_pend_q;
  logic [5:0]             pin_m_q;
  logic [5:0]             pin_s_q;
  logic [2:0]             strap_q;
  logic                   latch_pend_q;
  logic                   mgmt_q;
  logic                   rsvd_q;
  logic                   ref_sel_q;
  logic                   sata_sel_q;
  logic                   pwr_dn_cfg_q;
  logic                   pwr_dn_s;
  logic [1:0]             alloc_s;
  logic                   full_rst;
  logic                   rst_all;
  logic                   byte_done;
  logic                   addr_match;
  logic                   wr_en;
  logic [7:0]             rd_byte;

  sbac_line u_line (
    .clk   (clk),
    .nrst  (nrst),
    .scl_i (scl_i),
    .sda_i (sda_i),
    .ev    (ev.line)
  );

  // ----------------------------------------------------------------
  // Pin synchronisers and internal reset
  // ----------------------------------------------------------------
  // No reset: pins already settled at the first edge after release
  always_ff @(posedge clk) begin
    pin_m_q <= {~power_down_n, pll_alloc_mode, freq_strap_high,
                freq_strap_mid, freq_strap_low};
    pin_s_q <= pin_m_q;
  end

  assign pwr_dn_s  = pin_s_q[5];
  assign alloc_s   = pin_s_q[4:3];
  assign full_rst  = pwr_dn_s & ~pwr_dn_cfg_q;
  assign rst_all   = ~nrst | full_rst;
  assign legacy_power_down = pwr_dn_s & pwr_dn_cfg_q;

  // ----------------------------------------------------------------
  // Byte framing helpers
  // ----------------------------------------------------------------
  assign byte_done  = ev.scl_fall & full_q;
  assign addr_match = (sh_q[7:1] == sbac_pkg::SLAVE_ADDR_W[7:1]);
  assign wr_en      = (st_q == sbac_pkg::SBAC_WDATA) & byte_done & ~count_pend_q;
  assign rd_byte    = (off_q == sbac_pkg::REG0_INDEX) ? reg0_value
                                                      : sbac_pkg::UNMAPPED_READ;

  // ----------------------------------------------------------------
  // Slave protocol engine
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst_all) begin
      st_q         <= sbac_pkg::SBAC_IDLE;
      nxt_q        <= sbac_pkg::SBAC_IDLE;
      sh_q         <= 8'h00;
      tx_q         <= 8'h00;
      cnt_q        <= 3'h0;
      full_q       <= 1'b0;
      off_q        <= 7'h00;
      block_q      <= 1'b0;
      count_pend_q <= 1'b0;
      sda_oe_n     <= 1'b1;
    end else if (ev.start_det) begin
      st_q     <= sbac_pkg::SBAC_ADDR;
      cnt_q    <= 3'h0;
      full_q   <= 1'b0;
      sda_oe_n <= 1'b1;
    end else if (ev.stop_det) begin
      st_q     <= sbac_pkg::SBAC_IDLE;
      sda_oe_n <= 1'b1;
    end else begin
      case (st_q)
        sbac_pkg::SBAC_ADDR, sbac_pkg::SBAC_CMD, sbac_pkg::SBAC_WDATA: begin
          if (ev.scl_rise) begin
            sh_q   <= {sh_q[6:0], ev.sda_bit};
            cnt_q  <= cnt_q + 3'h1;
            full_q <= (cnt_q == 3'h7);
          end else if (byte_done) begin
            full_q <= 1'b0;
            cnt_q  <= 3'h0;
            if (st_q == sbac_pkg::SBAC_ADDR) begin
              if (addr_match) begin
                sda_oe_n <= 1'b0;
                st_q     <= sbac_pkg::SBAC_ACK;
                nxt_q    <= sh_q[0] ? sbac_pkg::SBAC_RDATA : sbac_pkg::SBAC_CMD;
              end else begin
                st_q <= sbac_pkg::SBAC_IDLE;
              end
            end else if (st_q == sbac_pkg::SBAC_CMD) begin
              sda_oe_n <= 1'b0;
              st_q     <= sbac_pkg::SBAC_ACK;
              nxt_q    <= sbac_pkg::SBAC_WDATA;
              block_q      <= (sh_q == sbac_pkg::BLOCK_CMD);
              count_pend_q <= (sh_q == sbac_pkg::BLOCK_CMD);
              off_q <= sh_q[sbac_pkg::CMD_BYTE_BIT] ? sh_q[6:0] : 7'h00;
            end else begin
              sda_oe_n <= 1'b0;
              st_q     <= sbac_pkg::SBAC_ACK;
              nxt_q    <= sbac_pkg::SBAC_WDATA;
              count_pend_q <= 1'b0;
              if (block_q && !count_pend_q) begin
                off_q <= off_q + 7'h01;
              end
            end
          end
        end
        sbac_pkg::SBAC_ACK: begin
          if (ev.scl_fall) begin
            st_q <= nxt_q;
            if (nxt_q == sbac_pkg::SBAC_RDATA) begin
              if (block_q && count_pend_q) begin
                tx_q         <= sbac_pkg::BLOCK_COUNT;
                sda_oe_n     <= sbac_pkg::BLOCK_COUNT[7];
                count_pend_q <= 1'b0;
              end else begin
                tx_q     <= rd_byte;
                sda_oe_n <= rd_byte[7];
                if (block_q) begin
                  off_q <= off_q + 7'h01;
                end
              end
            end else begin
              sda_oe_n <= 1'b1;
            end
          end
        end
        sbac_pkg::SBAC_RDATA: begin
          if (ev.scl_fall) begin
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == 3'h7) begin
              sda_oe_n <= 1'b1;
              st_q     <= sbac_pkg::SBAC_MACK;
            end else begin
              tx_q     <= {tx_q[6:0], 1'b0};
              sda_oe_n <= tx_q[6];
            end
          end
        end
        sbac_pkg::SBAC_MACK: begin
          if (ev.scl_rise) begin
            if (ev.sda_bit) begin
              st_q <= sbac_pkg::SBAC_IDLE;
            end else begin
              st_q  <= sbac_pkg::SBAC_ACK;
              nxt_q <= sbac_pkg::SBAC_RDATA;
            end
          end
        end
        default: begin
          st_q <= sbac_pkg::SBAC_IDLE;
        end
      endcase
    end
  end

  assign sda_o = 1'b0;

  // ----------------------------------------------------------------
  // Strap capture after every reset release
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst_all) begin
      latch_pend_q <= 1'b1;
      strap_q      <= 3'h0;
    end else if (latch_pend_q) begin
      latch_pend_q <= 1'b0;
      strap_q      <= pin_s_q[2:0];
    end
  end

  // ----------------------------------------------------------------
  // Control register 0 writable fields
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst_all) begin
      mgmt_q       <= sbac_pkg::MGMT_RST;
      rsvd_q       <= sbac_pkg::RSVD_RST;
      ref_sel_q    <= 1'b0;
      sata_sel_q   <= sbac_pkg::SATA_SEL_RST;
      pwr_dn_cfg_q <= sbac_pkg::PWR_DN_CFG_RST;
    end else if (latch_pend_q) begin
      ref_sel_q <= (alloc_s != sbac_pkg::ALLOC_MODE_PROC);
    end else if (wr_en && off_q == sbac_pkg::REG0_INDEX) begin
      mgmt_q       <= mgmt_q | sh_q[sbac_pkg::MGMT_BIT];
      rsvd_q       <= sh_q[sbac_pkg::RSVD_BIT];
      ref_sel_q    <= sh_q[sbac_pkg::REF_SEL_BIT];
      sata_sel_q   <= sh_q[sbac_pkg::SATA_SEL_BIT];
      pwr_dn_cfg_q <= sh_q[sbac_pkg::PWR_DN_CFG_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Register read view and loop selects
  // ----------------------------------------------------------------
  always_comb begin
    reg0_value = 8'h00;
    reg0_value[sbac_pkg::STRAP_HIGH_BIT] = strap_q[2];
    reg0_value[sbac_pkg::STRAP_MID_BIT]  = strap_q[1];
    reg0_value[sbac_pkg::STRAP_LOW_BIT]  = strap_q[0];
    reg0_value[sbac_pkg::MGMT_BIT]       = mgmt_q;
    reg0_value[sbac_pkg::RSVD_BIT]       = rsvd_q;
    reg0_value[sbac_pkg::REF_SEL_BIT]    = ref_sel_q;
    reg0_value[sbac_pkg::SATA_SEL_BIT]   = sata_sel_q;
    reg0_value[sbac_pkg::PWR_DN_CFG_BIT] = pwr_dn_cfg_q;
  end

  assign freq_strap_latched      = strap_q;
  assign management_mode         = mgmt_q;
  assign ref_from_express_loop   = ref_sel_q;
  assign express_cfg_eff         = ref_sel_q ? sbac_pkg::EXPRESS_CFG_OFF
                                             : second_reg_cfg;
  assign sata_from_usb_rate_loop = sata_sel_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_mgmt_sticky;
    (mgmt_q && !full_rst) |=> mgmt_q;
  endproperty
  a_mgmt_sticky: assert property (p_mgmt_sticky) else $error("mgmt bit cleared");
  property p_strap_hold;
    (!rst_all && !latch_pend_q) |=> (strap_q == $past(strap_q));
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap bits changed");
  property p_ref_reset;
    (latch_pend_q && !rst_all) |=> (ref_sel_q == ($past(alloc_s) != 2'h0));
  endproperty
  a_ref_reset: assert property (p_ref_reset) else $error("ref select reset bad");
  property p_full_rst;
    full_rst |=> (latch_pend_q && pwr_dn_cfg_q && !mgmt_q && !sata_sel_q && !rsvd_q);
  endproperty
  a_full_rst: assert property (p_full_rst) else $error("full reset incomplete");
  property p_legacy_keep;
    (legacy_power_down && !wr_en && !latch_pend_q) |=> (reg0_value == $past(reg0_value));
  endproperty
  a_legacy_keep: assert property (p_legacy_keep) else $error("config lost");
  property p_addr_ack;
    (st_q == sbac_pkg::SBAC_ADDR && byte_done && addr_match && !ev.start_det && !ev.stop_det)
      |=> (!sda_oe_n && st_q == sbac_pkg::SBAC_ACK);
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address not acked");
  property p_foreign;
    (st_q == sbac_pkg::SBAC_ADDR && byte_done && !addr_match && !ev.start_det)
      |=> sda_oe_n [*4];
  endproperty
  a_foreign: assert property (p_foreign) else $error("foreign address acked");
  property p_offset;
    (st_q == sbac_pkg::SBAC_CMD && byte_done && sh_q[7] && !ev.start_det && !ev.stop_det)
      |=> (off_q == $past(sh_q[6:0]) && !block_q);
  endproperty
  a_offset: assert property (p_offset) else $error("offset decode wrong");
  property p_block;
    (st_q == sbac_pkg::SBAC_CMD && byte_done && sh_q == 8'h00 && !ev.start_det)
      |=> (block_q && off_q == 7'h00 && count_pend_q);
  endproperty
  a_block: assert property (p_block) else $error("block decode wrong");
  property p_rd_nack;
    (st_q == sbac_pkg::SBAC_MACK && ev.scl_rise && ev.sda_bit && !ev.start_det)
      |=> (st_q == sbac_pkg::SBAC_IDLE && sda_oe_n);
  endproperty
  a_rd_nack: assert property (p_rd_nack) else $error("read not ended");
  property p_express_override;
    ref_from_express_loop |-> (express_cfg_eff == 4'h0);
  endproperty
  a_express_override: assert property (p_express_override) else $error("cfg leaks");

  c_byte_write: cover property (wr_en && !block_q);
  c_byte_read:  cover property (st_q == sbac_pkg::SBAC_MACK ##1 st_q == sbac_pkg::SBAC_IDLE);
  c_block_wr:   cover property (wr_en && block_q);
  c_mgmt_set:   cover property (!mgmt_q ##1 mgmt_q);

endmodule : sbac_top

/* File: tb/sbac_smbus_host.sv */
/*
  Two-wire bus master model: start, stop, byte write and byte read.
  Assumes the bench resolves the data line with a pull-up; the clock
  line stands high between frames.
*/
`timescale 1ns/10ps
module sbac_smbus_host (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_pull
);
  // ------------------------------------------------------------
  // Bit timing: 4 clk low, 4 clk high
  // ------------------------------------------------------------
  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic bit_io(input logic b, output logic r);
    @(negedge clk);
    sda_pull = !b;
    repeat (3) @(negedge clk);
    scl = 1'b1;
    repeat (2) @(negedge clk);
    r = sda;
    repeat (2) @(negedge clk);
    scl = 1'b0;
  endtask : bit_io

  // ------------------------------------------------------------
  // Frame conditions and bytes
  // ------------------------------------------------------------
  task automatic start;
    @(negedge clk);
    sda_pull = 1'b0;
    repeat (3) @(negedge clk);
    scl = 1'b1;
    repeat (4) @(negedge clk);
    sda_pull = 1'b1;
    repeat (4) @(negedge clk);
    scl = 1'b0;
  endtask : start

  task automatic stop;
    @(negedge clk);
    sda_pull = 1'b1;
    repeat (3) @(negedge clk);
    scl = 1'b1;
    repeat (4) @(negedge clk);
    sda_pull = 1'b0;
    repeat (4) @(negedge clk);
  endtask : stop

  task automatic wr_byte(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(v[i], r);
    end
    bit_io(1'b1, ack);
  endtask : wr_byte

  task automatic rd_byte(input logic last, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, v[i]);
    end
    bit_io(last, r);
  endtask : rd_byte
endmodule : sbac_smbus_host

/* File: tb/test_sbac_top.sv */
/*
  Self-checking bench for the byte access slave and control register 0.
  Assumes the master model in sbac_smbus_host and a pull-up on data.
*/
`timescale 1ns/10ps
module test_sbac_top;
  logic       clk = 1'b0;
  logic       nrst;
  logic       scl;
  logic       sda_pull;
  logic       sda_w;
  logic       sda_o;
  logic       sda_oe_n;
  logic [2:0] straps;
  logic [1:0] pll_alloc_mode;
  logic       power_down_n;
  logic [3:0] second_reg_cfg;
  logic [2:0] freq_strap_latched;
  logic       management_mode;
  logic       ref_from_express_loop;
  logic [3:0] express_cfg_eff;
  logic       sata_from_usb_rate_loop;
  logic       legacy_power_down;
  logic [7:0] reg0_value;
  logic [7:0] exp_r;
  logic [7:0] d;
  logic [7:0] v0;
  logic [7:0] v1;
  logic [7:0] seen_v;
  logic [7:0] exp_q[$];
  event       seen_ev;
  int         n_errors = 0;
  int         cmp_count = 0;

  always #25 clk = ~clk;
  assign sda_w = sda_pull ? 1'b0 : (sda_oe_n ? 1'b1 : sda_o);

  sbac_top i_sbac_top (
    .clk(clk), .nrst(nrst), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .freq_strap_high(straps[2]), .freq_strap_mid(straps[1]),
    .freq_strap_low(straps[0]), .pll_alloc_mode(pll_alloc_mode),
    .power_down_n(power_down_n), .second_reg_cfg(second_reg_cfg),
    .freq_strap_latched(freq_strap_latched), .management_mode(management_mode),
    .ref_from_express_loop(ref_from_express_loop), .express_cfg_eff(express_cfg_eff),
    .sata_from_usb_rate_loop(sata_from_usb_rate_loop),
    .legacy_power_down(legacy_power_down), .reg0_value(reg0_value)
  );

  sbac_smbus_host i_sbac_smbus_host (
    .clk(clk), .sda(sda_w), .scl(scl), .sda_pull(sda_pull)
  );

  // ------------------------------------------------------------
  // Result checking
  // ------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  always @(seen_ev) check(seen_v, exp_q.pop_front());

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    exp_q.push_back(exp);
    seen_v = seen;
    -> seen_ev;
    @(negedge clk);
  endtask : chk

  task automatic print_verdict;
    $display("Compares %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict

  // ------------------------------------------------------------
  // Stimulus helpers
  // ------------------------------------------------------------
  task automatic do_reset;
    nrst = 1'b0;
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    repeat (6) @(negedge clk);
  endtask : do_reset

  task automatic bus_wr(input logic [7:0] adr, input logic [7:0] cmd, input logic [7:0] dv);
    logic a;
    logic hit;
    hit = (adr === sbac_pkg::SLAVE_ADDR_W);
    i_sbac_smbus_host.start();
    i_sbac_smbus_host.wr_byte(adr, a);
    chk({7'h00, a}, {7'h00, !hit});
    if (hit) begin
      i_sbac_smbus_host.wr_byte(cmd, a);
      chk({7'h00, a}, 8'h00);
      i_sbac_smbus_host.wr_byte(dv, a);
      chk({7'h00, a}, 8'h00);
    end
    i_sbac_smbus_host.stop();
  endtask : bus_wr

  task automatic bus_rd(input logic [7:0] cmd, input logic two, output logic [7:0] r0,
                        output logic [7:0] r1);
    logic a;
    i_sbac_smbus_host.start();
    i_sbac_smbus_host.wr_byte(sbac_pkg::SLAVE_ADDR_W, a);
    chk({7'h00, a}, 8'h00);
    i_sbac_smbus_host.wr_byte(cmd, a);
    chk({7'h00, a}, 8'h00);
    i_sbac_smbus_host.start();
    i_sbac_smbus_host.wr_byte(sbac_pkg::SLAVE_ADDR_W | 8'h01, a);
    chk({7'h00, a}, 8'h00);
    r0 = 8'h00;
    if (two) begin
      i_sbac_smbus_host.rd_byte(1'b0, r0);
    end
    i_sbac_smbus_host.rd_byte(1'b1, r1);
    i_sbac_smbus_host.stop();
  endtask : bus_rd

  task automatic bus_blk_wr(input logic [7:0] dv);
    logic a;
    i_sbac_smbus_host.start();
    i_sbac_smbus_host.wr_byte(sbac_pkg::SLAVE_ADDR_W, a);
    chk({7'h00, a}, 8'h00);
    i_sbac_smbus_host.wr_byte(sbac_pkg::BLOCK_CMD, a);
    chk({7'h00, a}, 8'h00);
    i_sbac_smbus_host.wr_byte(8'h01, a);
    chk({7'h00, a}, 8'h00);
    i_sbac_smbus_host.wr_byte(dv, a);
    chk({7'h00, a}, 8'h00);
    i_sbac_smbus_host.stop();
  endtask : bus_blk_wr

  task automatic chk_out;
    chk(reg0_value, exp_r);
    chk({7'h00, management_mode}, {7'h00, exp_r[4]});
    chk({7'h00, ref_from_express_loop}, {7'h00, exp_r[2]});
    chk({7'h00, sata_from_usb_rate_loop}, {7'h00, exp_r[1]});
    chk({4'h0, express_cfg_eff}, exp_r[2] ? 8'h00 : {4'h0, second_reg_cfg});
    chk({5'h00, freq_strap_latched}, {5'h00, exp_r[7:5]});
  endtask : chk_out

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    power_down_n = 1'b1;
    second_reg_cfg = 4'h0;
    pll_alloc_mode = 2'h0;
    straps = 3'h0;
    void'($urandom(15726));
    for (int m = 0; m < 4; m++) begin
      pll_alloc_mode = m[1:0];
      straps = 3'($urandom);
      second_reg_cfg = 4'($urandom);
      do_reset();
      exp_r = {straps, 2'b00, m != 0, 2'b01};
      chk_out();
    end
    bus_rd(8'h80, 1'b0, v0, v1);
    chk(v1, exp_r);
    for (int k = 0; k < 2; k++) begin
      d = 8'($urandom);
      d[0] = 1'b1;
      d[2] = k[0];
      d[4] = !k[0];
      second_reg_cfg = 4'($urandom);
      bus_wr(sbac_pkg::SLAVE_ADDR_W, 8'h80, d);
      exp_r = {exp_r[7:5], 1'b1, d[3:0]};
      chk_out();
      bus_rd(sbac_pkg::BLOCK_CMD, 1'b1, v0, v1);
      chk(v0, sbac_pkg::BLOCK_COUNT);
      chk(v1, exp_r);
    end
    bus_wr(sbac_pkg::SLAVE_ADDR_W, 8'h81, 8'hFF);
    bus_rd(8'h85, 1'b0, v0, v1);
    chk(v1, sbac_pkg::UNMAPPED_READ);
    bus_wr(8'hA4, 8'h80, 8'h00);
    chk_out();
    bus_blk_wr(8'h09);
    exp_r = {exp_r[7:5], 5'h19};
    chk_out();
    power_down_n = 1'b0;
    repeat (5) @(negedge clk);
    chk({7'h00, legacy_power_down}, 8'h01);
    chk_out();
    power_down_n = 1'b1;
    bus_wr(sbac_pkg::SLAVE_ADDR_W, 8'h80, 8'h1E);
    chk(reg0_value, {exp_r[7:5], 5'h1E});
    straps = ~straps;
    repeat (5) @(negedge clk);
    power_down_n = 1'b0;
    repeat (8) @(negedge clk);
    power_down_n = 1'b1;
    repeat (5) @(negedge clk);
    exp_r = {straps, 5'h05};
    chk_out();
    print_verdict();
  end

  initial begin
    #1000000;
    n_errors++;
    print_verdict();
  end
endmodule : test_sbac_top
